// file: sbf_pkg.sv
`default_nettype none
package sbf_pkg;

   localparam int SBF_CLK_HZ = 10_000_000;

   // Framing bytes
   localparam logic [7:0] SBF_ESC = 8'h10;
   localparam logic [7:0] SBF_TERM = 8'h03;

   // Report identifiers
   localparam logic [7:0] SBF_ID_HEALTH = 8'h46;
   localparam logic [7:0] SBF_ID_MACHINE = 8'h4b;
   localparam logic [7:0] SBF_ID_VERSION = 8'h45;
   localparam logic [7:0] SBF_ID_XYZ_DBL = 8'h83;
   localparam logic [7:0] SBF_ID_XYZ_SGL = 8'h42;
   localparam logic [7:0] SBF_ID_LLA_DBL = 8'h84;
   localparam logic [7:0] SBF_ID_LLA_SGL = 8'h4a;
   localparam logic [7:0] SBF_ID_FIXMODE = 8'h82;
   localparam logic [7:0] SBF_ID_TIME = 8'h41;
   localparam logic [7:0] SBF_ID_MODE = 8'h6d;
   localparam logic [7:0] SBF_ID_BIAS = 8'h54;
   localparam logic [7:0] SBF_ID_SUPER = 8'h8f;
   localparam logic [7:0] SBF_SUB_EV_LONG = 8'h0b;
   localparam logic [7:0] SBF_SUB_EV_SHORT = 8'had;
   localparam logic [7:0] SBF_LEN_EV_LONG = 8'h4a;
   localparam logic [7:0] SBF_LEN_EV_SHORT = 8'h16;

   // Register map, byte addresses
   localparam logic [3:0] SBF_REG_CTRL = 4'h0;
   localparam logic [3:0] SBF_REG_STAT = 4'h4;

   // Control bit positions and reset value
   localparam int SBF_C_SILENT = 0;
   localparam int SBF_C_BG_OFF = 1;
   localparam int SBF_C_SINGLE = 2;
   localparam int SBF_C_PROTO = 3;
   localparam int SBF_C_EV_LONG = 4;
   localparam int SBF_C_EV_SHORT = 5;
   localparam logic [5:0] SBF_CTRL_RST = 6'h30;

   // Background report periods
   localparam int SBF_HLTH_IDLE_S = 16;
   localparam int SBF_HLTH_FIX_S = 30;
   localparam int SBF_TIME_IDLE_S = 16;
   localparam real SBF_TIME_FIX_MIN = 2.5;
   localparam int SBF_TIME_FIX_S = int'(SBF_TIME_FIX_MIN * 60.0);
   localparam int SBF_MODE_S = 30;

   // Report sources, lowest index wins
   localparam logic [2:0] SBF_PD_PWR = 3'h0;
   localparam logic [2:0] SBF_PD_POLL = 3'h1;
   localparam logic [2:0] SBF_PD_EVL = 3'h2;
   localparam logic [2:0] SBF_PD_EVS = 3'h3;
   localparam logic [2:0] SBF_PD_BIAS = 3'h4;
   localparam logic [2:0] SBF_PD_HLTH = 3'h5;
   localparam logic [2:0] SBF_PD_MODE = 3'h6;
   localparam logic [2:0] SBF_PD_TIME = 3'h7;
   localparam logic [2:0] SBF_PWR_LAST = 3'h5;

   typedef enum logic [2:0] {
      SBF_FK_NONE, SBF_FK_BYTE, SBF_FK_INT, SBF_FK_SINGLE, SBF_FK_DOUBLE
   } sbf_fk_t;

   typedef enum logic [2:0] {
      TX_IDLE, TX_START, TX_ID, TX_DATA, TX_END1, TX_END2
   } sbf_tx_t;

   typedef enum logic [1:0] {RX_HUNT, RX_ID, RX_BODY, RX_ESC} sbf_rx_t;

endpackage : sbf_pkg
`default_nettype wire

// file: sbf_framer.sv
// Overview of operation
// - Packets open with escape plus identifier, close with escape then terminator.
// - Identifier never equals the escape or terminator byte.
// - Sender doubles each escape byte found in the payload.
// - Receiver collapses each doubled escape to one data byte.
// - End only when terminator follows an odd run of escapes.
// - Multi-byte numbers go out most significant byte first.
// - Integers are two bytes, 16-bit two's complement.
// - Singles are four bytes, 24 significant bits.
// - Doubles are eight bytes, 52 mantissa bits.
// - Timing port takes protocol input or events; events blocked in protocol mode.
// - Event pulse triggers long (74) and/or short (22) report per mask.
// - Power-up reports 46,4B,45,83/42,84/4A,82; commands accepted after 82.
// - Health every 16 s idle, 30 s fixing, and on change.
// - With clock set, time every 16 s idle, 2.5 min fixing.
// - Mode report every 30 s and on tracked set change.
// - Periodic background reports can be switched off.
// - Silent mode sends only polled reports.
// - Clock-only modes emit bias report 54 with each fix.
//
// Added by the designer: the Avalon-MM register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module sbf_framer
   import sbf_pkg::*;
#(
   parameter int P_CYC_PER_SEC = SBF_CLK_HZ
) (
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic [3:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [3:0] i_avs_byteenable,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [7:0] i_rx_byte,
   input wire logic i_rx_strobe,
   output logic [7:0] o_pkt_data,
   output logic o_pkt_valid,
   output logic o_pkt_sop,
   output logic o_pkt_eop,
   output logic o_pkt_abort,
   output logic [7:0] o_tx_byte,
   output logic o_tx_valid,
   input wire logic i_tx_ready,
   output logic o_rep_start,
   output logic [7:0] o_rep_id,
   output logic [7:0] o_rep_sub,
   output logic [7:0] o_rep_len,
   input wire logic i_fld_valid,
   input wire sbf_fk_t i_fld_kind,
   input wire logic [63:0] i_fld_value,
   input wire logic i_fld_last,
   output logic o_fld_ready,
   input wire logic i_poll_valid,
   input wire logic [7:0] i_poll_id,
   output logic o_poll_ready,
   input wire logic i_diag_done,
   input wire logic i_fixing,
   input wire logic i_clock_set,
   input wire logic i_clock_only,
   input wire logic i_fix_strobe,
   input wire logic [7:0] i_health,
   input wire logic [31:0] i_sv_set,
   input wire logic i_event,
   output logic o_cmd_ready,
   output logic o_tport_proto_en
);

   ////////////////////////////////////////////////////////////////////////
   function automatic logic id_ok(input logic [7:0] b);
      return (b != SBF_ESC) && (b != SBF_TERM);
   endfunction : id_ok

   function automatic logic [3:0] fk_bytes(input sbf_fk_t k);
      unique case (k)
         SBF_FK_BYTE: return 4'h1;
         SBF_FK_INT: return 4'h2;
         SBF_FK_SINGLE: return 4'h4;
         SBF_FK_DOUBLE: return 4'h8;
         default: return 4'h0;
      endcase
   endfunction : fk_bytes

   function automatic logic [2:0] pick(input logic [7:0] r);
      logic [2:0] p;
      p = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (r[i]) begin
            p = 3'(i);
         end
      end
      return p;
   endfunction : pick

   function automatic logic [7:0] pwr_id(input logic [2:0] i, input logic sgl);
      unique case (i)
         3'h0: return SBF_ID_HEALTH;
         3'h1: return SBF_ID_MACHINE;
         3'h2: return SBF_ID_VERSION;
         3'h3: return sgl ? SBF_ID_XYZ_SGL : SBF_ID_XYZ_DBL;
         3'h4: return sgl ? SBF_ID_LLA_SGL : SBF_ID_LLA_DBL;
         default: return SBF_ID_FIXMODE;
      endcase
   endfunction : pwr_id

   ////////////////////////////////////////////////////////////////////////
   // Register slave
   logic ack, next_ack;
   logic [5:0] ctrl, next_ctrl;
   logic [31:0] next_rdata;
   logic busy, acc;
   logic [7:0] req;
   logic [2:0] pwr_idx;

   assign acc = (i_avs_read || i_avs_write) && !ack;
   assign o_avs_waitrequest = acc;
   assign o_tport_proto_en = ctrl[SBF_C_PROTO];

   always_comb begin
      next_ack = acc;
      next_ctrl = ctrl;
      next_rdata = o_avs_readdata;
      if (acc && i_avs_read) begin
         unique case (i_avs_address)
            SBF_REG_CTRL: next_rdata = {26'h0, ctrl};
            SBF_REG_STAT: next_rdata = {16'h0, req, 3'h0, pwr_idx, busy, o_cmd_ready};
            default: next_rdata = 32'h0;
         endcase
      end
      if (i_avs_write && ack && i_avs_address == SBF_REG_CTRL && i_avs_byteenable[0]) begin
         next_ctrl = i_avs_writedata[5:0];
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ack <= 1'b0;
         ctrl <= SBF_CTRL_RST;
         o_avs_readdata <= 32'h0;
      end else begin
         ack <= next_ack;
         ctrl <= next_ctrl;
         o_avs_readdata <= next_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Report scheduling and transmit framing
   logic [31:0] sec_cnt, next_sec_cnt;
   logic [7:0] hc, tc, mc, next_hc, next_tc, next_mc;
   logic [7:0] hlth_prev;
   logic [31:0] sv_prev;
   logic ev_s1, ev_s2, ev_s3;
   logic [7:1] pend, next_pend;
   logic [7:0] set;
   logic [7:0] poll_id, next_poll_id;
   logic ready, next_ready;
   logic [2:0] next_pwr_idx;
   sbf_tx_t tx_st, next_tx_st;
   logic [2:0] cur_idx, next_cur_idx;
   logic [63:0] sh, next_sh;
   logic [3:0] fld_cnt, next_fld_cnt;
   logic fld_last, next_fld_last;
   logic stuffed, next_stuffed;
   logic [7:0] next_tx_byte, next_id, next_sub, next_len;
   logic next_tx_valid, next_start;
   logic tick, live, bg, can_load, ev_rise;
   logic [7:0] hper, tper;

   assign tick = sec_cnt == 32'(P_CYC_PER_SEC - 1);
   assign live = ready && !ctrl[SBF_C_SILENT];
   assign bg = live && !ctrl[SBF_C_BG_OFF];
   assign can_load = !o_tx_valid || i_tx_ready;
   assign ev_rise = ev_s2 && !ev_s3;
   assign req = {pend, i_diag_done && !ready && !ctrl[SBF_C_SILENT]};
   assign busy = tx_st != TX_IDLE;
   assign o_poll_ready = !pend[SBF_PD_POLL];
   assign o_fld_ready = (tx_st == TX_DATA) && (fld_cnt == 4'h0);
   assign o_cmd_ready = ready;
   assign hper = i_fixing ? 8'(SBF_HLTH_FIX_S - 1) : 8'(SBF_HLTH_IDLE_S - 1);
   assign tper = i_fixing ? 8'(SBF_TIME_FIX_S - 1) : 8'(SBF_TIME_IDLE_S - 1);

   always_comb begin
      next_sec_cnt = tick ? 32'h0 : sec_cnt + 32'h1;
      next_hc = hc;
      next_tc = i_clock_set ? tc : 8'h0;
      next_mc = mc;
      set = 8'h0;
      if (tick) begin
         next_hc = (hc >= hper) ? 8'h0 : hc + 8'h1;
         next_mc = (mc >= 8'(SBF_MODE_S - 1)) ? 8'h0 : mc + 8'h1;
         if (i_clock_set) begin
            next_tc = (tc >= tper) ? 8'h0 : tc + 8'h1;
         end
      end
      set[SBF_PD_POLL] = i_poll_valid && o_poll_ready && id_ok(i_poll_id);
      set[SBF_PD_EVL] = ev_rise && live && !ctrl[SBF_C_PROTO]
         && ctrl[SBF_C_EV_LONG];
      set[SBF_PD_EVS] = ev_rise && live && !ctrl[SBF_C_PROTO] && ctrl[SBF_C_EV_SHORT];
      set[SBF_PD_BIAS] = live && i_fix_strobe && i_clock_only;
      set[SBF_PD_HLTH] = bg && ((tick && hc >= hper) || i_health != hlth_prev);
      set[SBF_PD_MODE] = bg && ((tick && mc >= 8'(SBF_MODE_S - 1))
         || i_sv_set != sv_prev);
      set[SBF_PD_TIME] = bg && i_clock_set && tick && tc >= tper;
      next_poll_id = set[SBF_PD_POLL] ? i_poll_id : poll_id;
      next_pend = pend;
      next_ready = ready || (i_diag_done && ctrl[SBF_C_SILENT]);
      next_pwr_idx = pwr_idx;
      next_tx_st = tx_st;
      next_cur_idx = cur_idx;
      next_sh = sh;
      next_fld_cnt = fld_cnt;
      next_fld_last = fld_last;
      next_stuffed = stuffed;
      next_tx_byte = o_tx_byte;
      next_tx_valid = o_tx_valid && !i_tx_ready;
      next_start = 1'b0;
      next_id = o_rep_id;
      next_sub = o_rep_sub;
      next_len = o_rep_len;
      unique case (tx_st)
         TX_IDLE: begin
            if (req != 8'h0) begin
               next_cur_idx = pick(req);
               next_start = 1'b1;
               next_tx_st = TX_START;
               next_sub = 8'h0;
               next_len = 8'h0;
               if (pick(req) != SBF_PD_PWR) begin
                  next_pend[pick(req)] = 1'b0;
               end
               unique case (pick(req))
                  SBF_PD_PWR: next_id = pwr_id(pwr_idx, ctrl[SBF_C_SINGLE]);
                  SBF_PD_POLL: next_id = poll_id;
                  SBF_PD_EVL: begin
                     next_id = SBF_ID_SUPER;
                     next_sub = SBF_SUB_EV_LONG;
                     next_len = SBF_LEN_EV_LONG;
                  end
                  SBF_PD_EVS: begin
                     next_id = SBF_ID_SUPER;
                     next_sub = SBF_SUB_EV_SHORT;
                     next_len = SBF_LEN_EV_SHORT;
                  end
                  SBF_PD_BIAS: next_id = SBF_ID_BIAS;
                  SBF_PD_HLTH: next_id = SBF_ID_HEALTH;
                  SBF_PD_MODE: next_id = SBF_ID_MODE;
                  SBF_PD_TIME: next_id = SBF_ID_TIME;
               endcase
            end
         end
         TX_START: begin
            if (can_load) begin
               next_tx_byte = SBF_ESC;
               next_tx_valid = 1'b1;
               next_tx_st = TX_ID;
            end
         end
         TX_ID: begin
            if (can_load) begin
               next_tx_byte = o_rep_id;
               next_tx_valid = 1'b1;
               next_tx_st = TX_DATA;
            end
         end
         TX_DATA: begin
            if (fld_cnt == 4'h0) begin
               if (i_fld_valid) begin
                  next_sh = i_fld_value << {4'h8 - fk_bytes(i_fld_kind), 3'h0};
                  next_fld_cnt = fk_bytes(i_fld_kind);
                  next_fld_last = i_fld_last;
                  next_stuffed = 1'b0;
                  if (i_fld_last && fk_bytes(i_fld_kind) == 4'h0) begin
                     next_tx_st = TX_END1;
                  end
               end
            end else if (can_load) begin
               next_tx_valid = 1'b1;
               if (sh[63:56] == SBF_ESC && !stuffed) begin
                  next_tx_byte = SBF_ESC;
                  next_stuffed = 1'b1;
               end else begin
                  next_tx_byte = sh[63:56];
                  next_sh = {sh[55:0], 8'h0};
                  next_fld_cnt = fld_cnt - 4'h1;
                  next_stuffed = 1'b0;
                  if (fld_cnt == 4'h1 && fld_last) begin
                     next_tx_st = TX_END1;
                  end
               end
            end
         end
         TX_END1: begin
            if (can_load) begin
               next_tx_byte = SBF_ESC;
               next_tx_valid = 1'b1;
               next_tx_st = TX_END2;
            end
         end
         TX_END2: begin
            if (can_load) begin
               next_tx_byte = SBF_TERM;
               next_tx_valid = 1'b1;
               next_tx_st = TX_IDLE;
               if (cur_idx == SBF_PD_PWR) begin
                  if (pwr_idx == SBF_PWR_LAST) begin
                     next_ready = 1'b1;
                  end else begin
                     next_pwr_idx = pwr_idx + 3'h1;
                  end
               end
            end
         end
         default: next_tx_st = TX_IDLE;
      endcase
      next_pend = next_pend | set[7:1];
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sec_cnt <= 32'h0;
         hc <= 8'h0;
         tc <= 8'h0;
         mc <= 8'h0;
         hlth_prev <= 8'h0;
         sv_prev <= 32'h0;
         ev_s1 <= 1'b0;
         ev_s2 <= 1'b0;
         ev_s3 <= 1'b0;
         pend <= 7'h0;
         poll_id <= 8'h0;
         ready <= 1'b0;
         pwr_idx <= 3'h0;
         tx_st <= TX_IDLE;
         cur_idx <= 3'h0;
         sh <= 64'h0;
         fld_cnt <= 4'h0;
         fld_last <= 1'b0;
         stuffed <= 1'b0;
         o_tx_byte <= 8'h0;
         o_tx_valid <= 1'b0;
         o_rep_start <= 1'b0;
         o_rep_id <= 8'h0;
         o_rep_sub <= 8'h0;
         o_rep_len <= 8'h0;
      end else begin
         sec_cnt <= next_sec_cnt;
         hc <= next_hc;
         tc <= next_tc;
         mc <= next_mc;
         hlth_prev <= i_health;
         sv_prev <= i_sv_set;
         ev_s1 <= i_event;
         ev_s2 <= ev_s1;
         ev_s3 <= ev_s2;
         pend <= next_pend;
         poll_id <= next_poll_id;
         ready <= next_ready;
         pwr_idx <= next_pwr_idx;
         tx_st <= next_tx_st;
         cur_idx <= next_cur_idx;
         sh <= next_sh;
         fld_cnt <= next_fld_cnt;
         fld_last <= next_fld_last;
         stuffed <= next_stuffed;
         o_tx_byte <= next_tx_byte;
         o_tx_valid <= next_tx_valid;
         o_rep_start <= next_start;
         o_rep_id <= next_id;
         o_rep_sub <= next_sub;
         o_rep_len <= next_len;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive deframer, one byte held back to mark the end
   sbf_rx_t rx_st, next_rx_st;
   logic [7:0] hold, next_hold;
   logic hold_sop, next_hold_sop;
   logic [7:0] next_pkt_data;
   logic next_pkt_valid, next_pkt_sop, next_pkt_eop, next_pkt_abort;

   always_comb begin
      next_rx_st = rx_st;
      next_hold = hold;
      next_hold_sop = hold_sop;
      next_pkt_data = o_pkt_data;
      next_pkt_valid = 1'b0;
      next_pkt_sop = o_pkt_sop;
      next_pkt_eop = o_pkt_eop;
      next_pkt_abort = 1'b0;
      if (i_rx_strobe) begin
         unique case (rx_st)
            RX_HUNT: begin
               if (i_rx_byte == SBF_ESC) begin
                  next_rx_st = RX_ID;
               end
            end
            RX_ID: begin
               if (id_ok(i_rx_byte)) begin
                  next_hold = i_rx_byte;
                  next_hold_sop = 1'b1;
                  next_rx_st = RX_BODY;
               end else begin
                  next_rx_st = RX_HUNT;
               end
            end
            RX_BODY: begin
               if (i_rx_byte == SBF_ESC) begin
                  next_rx_st = RX_ESC;
               end else begin
                  next_pkt_data = hold;
                  next_pkt_valid = 1'b1;
                  next_pkt_sop = hold_sop;
                  next_pkt_eop = 1'b0;
                  next_hold = i_rx_byte;
                  next_hold_sop = 1'b0;
               end
            end
            RX_ESC: begin
               if (i_rx_byte == SBF_ESC) begin
                  next_pkt_data = hold;
                  next_pkt_valid = 1'b1;
                  next_pkt_sop = hold_sop;
                  next_pkt_eop = 1'b0;
                  next_hold = SBF_ESC;
                  next_hold_sop = 1'b0;
                  next_rx_st = RX_BODY;
               end else if (i_rx_byte == SBF_TERM) begin
                  next_pkt_data = hold;
                  next_pkt_valid = 1'b1;
                  next_pkt_sop = hold_sop;
                  next_pkt_eop = 1'b1;
                  next_rx_st = RX_HUNT;
               end else begin
                  next_pkt_abort = 1'b1;
                  next_hold = i_rx_byte;
                  next_hold_sop = 1'b1;
                  next_rx_st = RX_BODY;
               end
            end
         endcase
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         rx_st <= RX_HUNT;
         hold <= 8'h0;
         hold_sop <= 1'b0;
         o_pkt_data <= 8'h0;
         o_pkt_valid <= 1'b0;
         o_pkt_sop <= 1'b0;
         o_pkt_eop <= 1'b0;
         o_pkt_abort <= 1'b0;
      end else begin
         rx_st <= next_rx_st;
         hold <= next_hold;
         hold_sop <= next_hold_sop;
         o_pkt_data <= next_pkt_data;
         o_pkt_valid <= next_pkt_valid;
         o_pkt_sop <= next_pkt_sop;
         o_pkt_eop <= next_pkt_eop;
         o_pkt_abort <= next_pkt_abort;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   sequence s_tail;
      (tx_st == TX_END1 && can_load) ##1 (o_tx_byte == SBF_ESC && tx_st == TX_END2);
   endsequence

   property p_frame;
      s_tail ##0 can_load |=> o_tx_valid && o_tx_byte == SBF_TERM && tx_st == TX_IDLE;
   endproperty
   a_frame: assert property (p_frame) else $error("frame tail wrong");

   property p_id_legal;
      (tx_st == TX_ID && can_load && cur_idx == SBF_PD_POLL) |=> id_ok(o_tx_byte);
   endproperty
   a_id_legal: assert property (p_id_legal) else $error("illegal identifier sent");

   sequence s_stuff;
      tx_st == TX_DATA && fld_cnt != 4'h0 && can_load && sh[63:56] == SBF_ESC && !stuffed;
   endsequence

   property p_stuff;
      s_stuff |=> o_tx_byte == SBF_ESC && stuffed && fld_cnt == $past(fld_cnt);
   endproperty
   a_stuff: assert property (p_stuff) else $error("escape not doubled");

   property p_unstuff;
      (rx_st == RX_ESC && i_rx_strobe && i_rx_byte == SBF_ESC)
         |=> rx_st == RX_BODY && hold == SBF_ESC && !hold_sop;
   endproperty
   a_unstuff: assert property (p_unstuff) else $error("doubled escape kept");

   property p_eop;
      (rx_st == RX_ESC && i_rx_strobe && i_rx_byte == SBF_TERM)
         |=> o_pkt_valid && o_pkt_eop && o_pkt_data == $past(hold) && rx_st == RX_HUNT;
   endproperty
   a_eop: assert property (p_eop) else $error("end of packet missed");

   property p_msb;
      (o_fld_ready && i_fld_valid && i_fld_kind == SBF_FK_DOUBLE)
         |=> sh == $past(i_fld_value) && fld_cnt == 4'h8;
   endproperty
   a_msb: assert property (p_msb) else $error("double not aligned high");

   property p_event_block;
      (ev_rise && ctrl[SBF_C_PROTO] && !pend[SBF_PD_EVL]) |=> !pend[SBF_PD_EVL];
   endproperty
   a_event_block: assert property (p_event_block) else $error("event in protocol mode");

   property p_ready;
      $rose(ready) && !ctrl[SBF_C_SILENT]
         |-> $past(tx_st) == TX_END2 && $past(cur_idx) == SBF_PD_PWR
         && $past(o_rep_id) == SBF_ID_FIXMODE;
   endproperty
   a_ready: assert property (p_ready) else $error("ready before final report");

   property p_silent;
      (ctrl[SBF_C_SILENT] && ready && pend == 7'h0 && tx_st == TX_IDLE)
         |=> tx_st == TX_IDLE;
   endproperty
   a_silent: assert property (p_silent) else $error("unpolled report in silent mode");

   property p_resync;
      (rx_st == RX_ESC && i_rx_strobe && id_ok(i_rx_byte))
         |=> o_pkt_abort && hold_sop && !o_pkt_valid;
   endproperty
   a_resync: assert property (p_resync) else $error("restart not taken");

endmodule : sbf_framer
`default_nettype wire

// file: sbf_host.sv
`timescale 1ns/100ps
`default_nettype none
module sbf_host (
   input wire logic i_clk,
   output logic o_tx_ready = 1'b0
);
   // Takes framed bytes, stalling at random
   always @(posedge i_clk) o_tx_ready <= $urandom % 3 != 0;
endmodule : sbf_host
`default_nettype wire

// file: stuffed_binary_packet_framer_bench.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin errors++; \
   $display("BAD %0t mismatch", $time); end end
module stuffed_binary_packet_framer_bench;
   import sbf_pkg::*;
   logic i_clk = 0, i_reset = 1, i_avs_read = 0, i_avs_write = 0, i_rx_strobe = 0, i_event = 0;
   logic i_diag_done = 0, i_tx_ready, o_avs_waitrequest, o_pkt_valid, o_pkt_sop, o_pkt_eop;
   logic o_pkt_abort, o_tx_valid, o_rep_start, o_cmd_ready, o_tport_proto_en;
   logic [3:0] i_avs_address = 0;
   logic [31:0] i_avs_writedata = 0, o_avs_readdata, q;
   logic [7:0] i_rx_byte = 0, i_health = 0, o_pkt_data, o_tx_byte, o_rep_id, r;
   logic [7:0] o_rep_sub, o_rep_len, txq[$];
   logic [63:0] i_fld_value = 0, v;
   logic i_poll_valid = 0, i_clock_only = 0, i_fix_strobe = 0;
   logic [7:0] i_poll_id = 0;
   logic [3:0] i_avs_byteenable = 4'hf;
   sbf_fk_t i_fld_kind = SBF_FK_INT;
   logic [9:0] rxq[$];
   logic [23:0] reps[$];
   logic [7:0] pu[6] = '{8'h46, 8'h4b, 8'h45, 8'h83, 8'h84, 8'h82};
   int errors = 0, checks_done = 0, aborts = 0, n, nb;
   sbf_framer #(.P_CYC_PER_SEC(1000)) u_sbf_framer (.i_clk, .i_reset, .i_avs_address,
      .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
      .o_avs_waitrequest, .i_rx_byte, .i_rx_strobe, .o_pkt_data, .o_pkt_valid, .o_pkt_sop,
      .o_pkt_eop, .o_pkt_abort, .o_tx_byte, .o_tx_valid, .i_tx_ready, .o_rep_start, .o_rep_id,
      .o_rep_sub, .o_rep_len, .i_fld_valid(1'b1), .i_fld_kind, .i_fld_value,
      .i_fld_last(1'b1), .o_fld_ready(), .i_poll_valid, .i_poll_id,
      .o_poll_ready(), .i_diag_done, .i_fixing(1'b0), .i_clock_set(1'b0),
      .i_clock_only, .i_fix_strobe, .i_health, .i_sv_set(32'h0), .i_event,
      .o_cmd_ready, .o_tport_proto_en);
   sbf_host u_sbf_host (.i_clk, .o_tx_ready(i_tx_ready));
   always #50 i_clk = ~i_clk;
   ////////////////////////////////////////////////////////////////////////////////
   // Field supplier and stream model
   always @(posedge i_clk) begin
      if (o_rep_start) begin
         v = {$urandom, $urandom};
         v[15:8] = SBF_ESC;
         nb = v[63] ? 8 : 2;
         if (v[63]) i_fld_kind <= SBF_FK_DOUBLE;
         else i_fld_kind <= SBF_FK_INT;
         i_fld_value <= v;
         reps.push_back({o_rep_id, o_rep_sub, o_rep_len});
         txq = {txq, SBF_ESC, o_rep_id};
         for (int i = nb - 1; i >= 0; i--) begin
            if (v[8*i+:8] == SBF_ESC) txq.push_back(SBF_ESC);
            txq.push_back(v[8*i+:8]);
         end
         txq = {txq, SBF_ESC, SBF_TERM};
      end
      if (o_tx_valid && i_tx_ready) `CHK(o_tx_byte, txq.pop_front())
      if (o_pkt_valid) `CHK({o_pkt_sop, o_pkt_eop, o_pkt_data}, rxq.pop_front())
      if (o_pkt_abort) aborts++;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : final_report
   task automatic lim();
      if (n >= 4000) begin
         errors++;
         final_report();
      end
   endtask : lim
   task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
      n = 0;
      @(posedge i_clk);
      i_avs_address <= a;
      i_avs_writedata <= d;
      i_avs_write <= w;
      i_avs_read <= !w;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_avs_waitrequest !== 1'b0 && n < 4000);
      q = o_avs_readdata;
      i_avs_write <= 0;
      i_avs_read <= 0;
      lim();
   endtask : bus
   task automatic idle(input int m);
      n = 0;
      while ((txq.size() != 0 || o_tx_valid !== 1'b0 || n < m) && n < 4000) begin
         @(posedge i_clk);
         n++;
      end
      lim();
   endtask : idle
   task automatic rxs(input logic [7:0] s[$]);
      foreach (s[i]) begin
         @(posedge i_clk);
         i_rx_byte <= s[i];
         i_rx_strobe <= 1;
      end
      @(posedge i_clk);
      i_rx_strobe <= 0;
   endtask : rxs
   task automatic ev(input logic [31:0] c, input logic [7:0] h);
      bus(1, SBF_REG_CTRL, c);
      reps.delete();
      i_health <= h;
      i_event <= 1;
      repeat (4) @(posedge i_clk);
      i_event <= 0;
      idle(300);
   endtask : ev
   task automatic poll(input logic [7:0] id);
      reps.delete();
      i_poll_valid <= 1;
      i_poll_id <= id;
      @(posedge i_clk);
      i_poll_valid <= 0;
      idle(300);
   endtask : poll
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(41149));
      repeat (6) @(posedge i_clk);
      i_reset <= 0;
      bus(0, SBF_REG_CTRL, 0);
      `CHK(q, 32'h30)
      bus(0, 4'h8, 0);
      `CHK(q, 32'h0)
      i_diag_done <= 1;
      n = 0;
      while (o_cmd_ready !== 1'b1 && n < 4000) begin
         @(posedge i_clk);
         n++;
      end
      lim();
      `CHK(reps.size(), 6)
      foreach (pu[i]) `CHK(reps[i][23:16], pu[i])
      idle(0);
      rxq = {10'h246, 10'h001, 10'h110, 10'h247, 10'h010, 10'h103, 10'h248, 10'h222, 10'h107};
      rxs({8'h10, 8'h46, 8'h01, 8'h10, 8'h10, 8'h10, 8'h03});
      rxs({8'h10, 8'h47, 8'h10, 8'h10, 8'h03, 8'h10, 8'h03});
      rxs({8'h10, 8'h03, 8'h55, 8'h10, 8'h48, 8'h05, 8'h10, 8'h22, 8'h07, 8'h10, 8'h03});
      idle(10);
      `CHK(rxq.size(), 0)
      `CHK(aborts, 1)
      ev(32'h30, 8'h00);
      `CHK(reps.size(), 2)
      `CHK(reps[0], 24'h8f0b4a)
      `CHK(reps[1], 24'h8fad16)
      ev(32'h38, 8'h00);
      `CHK(o_tport_proto_en, 1'b1)
      `CHK(reps.size(), 0)
      ev(32'h3a, 8'h01);
      `CHK(reps.size(), 0)
      ev(32'h31, 8'h02);
      `CHK(reps.size(), 0)
      ev(32'h08, 8'h03);
      `CHK(reps[$][23:16], SBF_ID_HEALTH)
      poll(SBF_ESC);
      `CHK(reps.size(), 0)
      r = $urandom;
      r[5] = 1'b1;
      poll(r);
      `CHK(reps.size(), 1)
      `CHK(reps[0][23:16], r)
      reps.delete();
      i_clock_only <= 1;
      i_fix_strobe <= 1;
      @(posedge i_clk);
      i_fix_strobe <= 0;
      idle(300);
      `CHK(reps.size(), 1)
      `CHK(reps[0][23:16], SBF_ID_BIAS)
      i_avs_byteenable <= 4'h0;
      bus(1, SBF_REG_CTRL, 32'h3f);
      bus(0, SBF_REG_CTRL, 0);
      `CHK(q, 32'h08)
      final_report();
   end
endmodule : stuffed_binary_packet_framer_bench
`default_nettype wire
